// ### core/adcec_pkg.sv
// Functional notes
// - Result-ready event is a one-clock pulse, same condition as the result-ready flag
// - With event start enabled, each rising start-event edge while idle begins a conversion; edges during a conversion are lost except in its completion cycle
// - Detected event edge sets the begin-conversion bit, then conversion starts
// - Conversion end sets result-ready flag and clears the begin-conversion bit unless free-running or a new event edge arrives
// - Result-ready on new result; window flag when window mode condition holds
// - Interrupt flags are set whatever the enable bits say
// - Interrupt request is enable AND flag, held until the flag clears
// - Debug halt freezes the block unless debug-keep-running is set
// - Standby blocks new conversion starts unless run-in-standby; software starts are blocked either way
// - In standby, only event starts or free-running continuation are accepted
// - In standby, peripheral clock is requested only while converting
// - Power-down freezes conversion; resumes on wake; result marked invalid
// - Warm-up delay after power-down or plain standby via initialization delay
// - Software start begins conversion on next converter clock edge
// - Free-running repeats conversions after a software start
// - Initialization delay codes 0..5 give 0,16,32,64,128,256 converter cycles
// - Window compared once, after the last accumulated sample
package adcec_pkg;
    // Register indices; byte address is four times the index
    localparam logic [4:0] REG_CONTROL_A    = 5'h00;
    localparam logic [4:0] REG_ACCUM_CTRL   = 5'h01;
    localparam logic [4:0] REG_CLKDIV_CTRL  = 5'h02;
    localparam logic [4:0] REG_DELAY_CTRL   = 5'h03;
    localparam logic [4:0] REG_WINMODE_CTRL = 5'h04;
    localparam logic [4:0] REG_SAMPLE_LEN   = 5'h05;
    localparam logic [4:0] REG_POS_SEL      = 5'h08;
    localparam logic [4:0] REG_NEG_SEL      = 5'h09;
    localparam logic [4:0] REG_CONV_CMD     = 5'h0A;
    localparam logic [4:0] REG_EVENT_CTRL   = 5'h0B;
    localparam logic [4:0] REG_IRQ_ENABLE   = 5'h0C;
    localparam logic [4:0] REG_IRQ_FLAGS    = 5'h0D;
    localparam logic [4:0] REG_DEBUG        = 5'h0E;
    localparam logic [4:0] REG_BYTE_STAGE   = 5'h0F;
    localparam logic [4:0] REG_CONV_OUT     = 5'h10;
    localparam logic [4:0] REG_WIN_LOW      = 5'h12;
    localparam logic [4:0] REG_WIN_HIGH     = 5'h14;
    // Field positions
    localparam int BIT_ENABLE    = 0;
    localparam int BIT_FREE_RUN  = 1;
    localparam int BIT_RES_SEL   = 2;
    localparam int BIT_LEFT_ADJ  = 4;
    localparam int BIT_RUN_STDBY = 7;
    localparam int BIT_BEGIN     = 0;
    localparam int BIT_HALT      = 1;
    localparam int BIT_RESULT_READY    = 0;
    localparam int BIT_WINCMP    = 1;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // Converter clock cycles per conversion, half cycles rounded up
    localparam logic [8:0] CONV_TICKS_12 = 9'h00E;
    localparam logic [8:0] CONV_TICKS_10 = 9'h00C;
    // Window modes
    localparam logic [2:0] WIN_BELOW   = 3'h1;
    localparam logic [2:0] WIN_ABOVE   = 3'h2;
    localparam logic [2:0] WIN_INSIDE  = 3'h3;
    localparam logic [2:0] WIN_OUTSIDE = 3'h4;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_INIT = 2'b01,
        ST_CONV = 2'b10,
        ST_SDLY = 2'b11
    } adcec_st_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } adcec_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } adcec_wb_rsp_t;

    typedef struct packed {
        logic [1:0]  evs;
        logic        ev_d;
        logic [7:0]  ctla;
        logic [7:0]  accc;
        logic [7:0]  divc;
        logic [7:0]  dlyc;
        logic [7:0]  winc;
        logic [7:0]  slen;
        logic [7:0]  psel;
        logic [7:0]  nsel;
        logic [7:0]  tmp;
        logic        evctl;
        logic        dbg;
        logic [1:0]  ien;
        logic [1:0]  iflg;
        logic        begin_conversion_bit;
        logic [15:0] res;
        logic [15:0] window_low_threshold;
        logic [15:0] window_high_threshold;
        logic        ack;
        logic [31:0] rdat;
        adcec_st_t   st;
        logic [7:0]  pdiv;
        logic [8:0]  cnt;
        logic [7:0]  nsmp;
        logic [18:0] acc;
        logic        init_pend;
        logic        en_d;
        logic        sleep_d;
        logic        res_bad;
        logic        evp;
    } adcec_state_t;
endpackage

// ### core/adcec_top.sv
`timescale 1ns/100ps
module adcec_top import adcec_pkg::*; (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire adcec_wb_req_t wb_req_i,
    output adcec_wb_rsp_t      wb_rsp_o,
    input  wire logic          start_event_i,
    input  wire logic [11:0]   sample_i,
    input  wire logic          debug_halt_i,
    input  wire logic          standby_i,
    input  wire logic          powerdown_i,
    output logic               result_ready_evt_o,
    output logic               irq_result_ready_o,
    output logic               irq_window_o,
    output logic               clk_request_o,
    output logic               conv_busy_o
);
    adcec_state_t q_r;
    adcec_state_t q_nxt;

    // Prescaler code to terminal count of the divider
    function automatic logic [7:0] presc_lim(input logic [3:0] c);
        case (c)
            4'h0: presc_lim = 8'h01;
            4'h1: presc_lim = 8'h03;
            4'h2: presc_lim = 8'h07;
            4'h3: presc_lim = 8'h0B;
            4'h4: presc_lim = 8'h0F;
            4'h5: presc_lim = 8'h13;
            4'h6: presc_lim = 8'h17;
            4'h7: presc_lim = 8'h1B;
            4'h8: presc_lim = 8'h1F;
            4'h9: presc_lim = 8'h2F;
            4'hA: presc_lim = 8'h3F;
            4'hB: presc_lim = 8'h5F;
            4'hC: presc_lim = 8'h7F;
            default: presc_lim = 8'hFF;
        endcase
    endfunction

    // Initialization delay code to converter cycles
    function automatic logic [8:0] init_ticks(input logic [2:0] c);
        case (c)
            3'h1: init_ticks = 9'h010;
            3'h2: init_ticks = 9'h020;
            3'h3: init_ticks = 9'h040;
            3'h4: init_ticks = 9'h080;
            3'h5: init_ticks = 9'h100;
            default: init_ticks = 9'h000;
        endcase
    endfunction

    logic        wr;
    logic        rd;
    logic [4:0]  idx;
    logic        en;
    logic        stby_off;
    logic        frozen;
    logic        tick;
    logic        ev_edge;
    logic        done;
    logic        sleep_now;
    logic [8:0]  conv_len;
    logic [11:0] smp;
    logic [18:0] acc_sum;
    logic [15:0] r;
    logic [7:0]  last;
    logic        win_hit;
    logic [31:0] rd_mux;
    logic        halt_req;

    // Next-state logic
    always_comb begin
        q_nxt     = q_r;
        idx       = wb_req_i.adr[6:2];
        wr        = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !q_r.ack;
        rd        = wb_req_i.cyc && wb_req_i.stb && !q_r.ack;
        halt_req  = wr && idx == REG_CONV_CMD && wb_req_i.sel[0] && wb_req_i.dat[BIT_HALT];
        en        = q_r.ctla[BIT_ENABLE];
        stby_off  = standby_i && !q_r.ctla[BIT_RUN_STDBY];
        frozen    = powerdown_i || (debug_halt_i && !q_r.dbg);
        sleep_now = stby_off || powerdown_i;
        tick      = (q_r.pdiv == presc_lim(q_r.divc[3:0]));
        conv_len  = q_r.ctla[BIT_RES_SEL] ? CONV_TICKS_10 : CONV_TICKS_12;
        conv_len  = conv_len + {1'b0, q_r.slen};
        smp       = q_r.ctla[BIT_RES_SEL] ? {2'h0, sample_i[11:2]} : sample_i;
        acc_sum   = q_r.acc + {7'h00, smp};
        last      = 8'((9'h001 << q_r.accc[2:0]) - 9'h001);
        done      = 1'b0;
        win_hit   = 1'b0;
        r         = 16'h0000;
        q_nxt.ack = rd;
        q_nxt.evp = 1'b0;

        // Event line synchroniser and edge detect
        q_nxt.evs  = {q_r.evs[0], start_event_i};
        q_nxt.ev_d = q_r.evs[1];
        ev_edge    = q_r.evs[1] && !q_r.ev_d && q_r.evctl && en;

        // Warm-up on enable or on wake from power-down or plain standby
        q_nxt.en_d    = en;
        q_nxt.sleep_d = sleep_now;
        if ((en && !q_r.en_d) || (q_r.sleep_d && !sleep_now)) begin
            q_nxt.init_pend = 1'b1;
        end

        // Converter clock divider, stopped while frozen
        if (!frozen) begin
            q_nxt.pdiv = tick ? 8'h00 : q_r.pdiv + 8'h01;
        end

        // Register writes
        if (wr) begin
            unique case (idx)
                REG_CONTROL_A:    if (wb_req_i.sel[0]) q_nxt.ctla = wb_req_i.dat[7:0];
                REG_ACCUM_CTRL:   if (wb_req_i.sel[0]) q_nxt.accc = {5'h00, wb_req_i.dat[2:0]};
                REG_CLKDIV_CTRL:  if (wb_req_i.sel[0]) q_nxt.divc = {4'h0, wb_req_i.dat[3:0]};
                REG_DELAY_CTRL:   if (wb_req_i.sel[0]) q_nxt.dlyc = wb_req_i.dat[7:0] & 8'hEF;
                REG_WINMODE_CTRL: if (wb_req_i.sel[0]) q_nxt.winc = {5'h00, wb_req_i.dat[2:0]};
                REG_SAMPLE_LEN:   if (wb_req_i.sel[0]) q_nxt.slen = wb_req_i.dat[7:0];
                REG_POS_SEL:      if (wb_req_i.sel[0]) q_nxt.psel = {1'b0, wb_req_i.dat[6:0]};
                REG_NEG_SEL:      if (wb_req_i.sel[0]) q_nxt.nsel = {1'b0, wb_req_i.dat[6:0]};
                REG_EVENT_CTRL:   if (wb_req_i.sel[0]) q_nxt.evctl = wb_req_i.dat[0];
                REG_IRQ_ENABLE:   if (wb_req_i.sel[0]) q_nxt.ien = wb_req_i.dat[1:0];
                REG_IRQ_FLAGS:    if (wb_req_i.sel[0]) q_nxt.iflg = q_r.iflg & ~wb_req_i.dat[1:0];
                REG_DEBUG:        if (wb_req_i.sel[0]) q_nxt.dbg = wb_req_i.dat[0];
                REG_BYTE_STAGE:   if (wb_req_i.sel[0]) q_nxt.tmp = wb_req_i.dat[7:0];
                REG_WIN_LOW: begin
                    if (wb_req_i.sel[0]) q_nxt.window_low_threshold[7:0] = wb_req_i.dat[7:0];
                    if (wb_req_i.sel[1]) q_nxt.window_low_threshold[15:8] = wb_req_i.dat[15:8];
                end
                REG_WIN_HIGH: begin
                    if (wb_req_i.sel[0]) q_nxt.window_high_threshold[7:0] = wb_req_i.dat[7:0];
                    if (wb_req_i.sel[1]) q_nxt.window_high_threshold[15:8] = wb_req_i.dat[15:8];
                end
                REG_CONV_CMD: begin
                    if (wb_req_i.sel[0] && wb_req_i.dat[BIT_BEGIN] && !standby_i) begin
                        q_nxt.begin_conversion_bit = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        // Event start
        if (ev_edge) begin
            q_nxt.begin_conversion_bit = 1'b1;
        end

        // Conversion sequencer
        if (!en) begin
            q_nxt.st     = ST_IDLE;
            q_nxt.begin_conversion_bit = 1'b0;
        end else if (!frozen && tick) begin
            unique case (q_r.st)
                ST_IDLE: begin
                    if (q_r.begin_conversion_bit && !stby_off) begin
                        q_nxt.nsmp = 8'h00;
                        q_nxt.acc  = 19'h00000;
                        if (q_r.init_pend) begin
                            q_nxt.st  = ST_INIT;
                            q_nxt.cnt = init_ticks(q_r.dlyc[7:5]);
                        end else begin
                            q_nxt.st  = ST_CONV;
                            q_nxt.cnt = conv_len;
                        end
                    end
                end
                ST_INIT: begin
                    if (q_r.cnt == 9'h000) begin
                        q_nxt.init_pend = 1'b0;
                        q_nxt.st        = ST_CONV;
                        q_nxt.cnt       = conv_len;
                    end else begin
                        q_nxt.cnt = q_r.cnt - 9'h001;
                    end
                end
                ST_CONV: begin
                    if (q_r.cnt == 9'h000) begin
                        q_nxt.acc = acc_sum;
                        if (q_r.nsmp == last) begin
                            done     = 1'b1;
                            q_nxt.st = ST_IDLE;
                        end else begin
                            q_nxt.nsmp = q_r.nsmp + 8'h01;
                            q_nxt.st   = ST_SDLY;
                            q_nxt.cnt  = {5'h00, q_r.dlyc[3:0]};
                        end
                    end else begin
                        q_nxt.cnt = q_r.cnt - 9'h001;
                    end
                end
                ST_SDLY: begin
                    if (q_r.cnt == 9'h000) begin
                        q_nxt.st  = ST_CONV;
                        q_nxt.cnt = conv_len;
                    end else begin
                        q_nxt.cnt = q_r.cnt - 9'h001;
                    end
                end
            endcase
        end

        // Power-down during a conversion spoils the result
        if (powerdown_i && q_r.st != ST_IDLE) begin
            q_nxt.res_bad = 1'b1;
        end

        // Result formatting and completion flags
        if (q_r.accc[2:0] == 3'h0) begin
            r = q_r.ctla[BIT_LEFT_ADJ]
                ? (q_r.ctla[BIT_RES_SEL] ? {smp[9:0], 6'h00} : {smp, 4'h0})
                : {4'h0, smp};
        end else if (q_r.accc[2:0] <= 3'h4) begin
            r = acc_sum[15:0];
        end else begin
            r = 16'(acc_sum >> (q_r.accc[2:0] - 3'h4));
        end
        unique case (q_r.winc[2:0])
            WIN_BELOW:   win_hit = r < q_r.window_low_threshold;
            WIN_ABOVE:   win_hit = r > q_r.window_high_threshold;
            WIN_INSIDE:  win_hit = (r > q_r.window_low_threshold) && (r < q_r.window_high_threshold);
            WIN_OUTSIDE: win_hit = (r < q_r.window_low_threshold) || (r > q_r.window_high_threshold);
            default:     win_hit = 1'b0;
        endcase
        if (done) begin
            q_nxt.res     = q_r.res_bad ? 16'h0000 : r;
            q_nxt.res_bad = 1'b0;
            q_nxt.iflg[BIT_RESULT_READY] = 1'b1;
            q_nxt.evp     = 1'b1;
            if (win_hit) begin
                q_nxt.iflg[BIT_WINCMP] = 1'b1;
            end
            q_nxt.begin_conversion_bit  = q_r.ctla[BIT_FREE_RUN] || ev_edge;
        end
        // Halt wins over a sequencer step or free-running restart in the same cycle
        if (halt_req) begin
            q_nxt.begin_conversion_bit = 1'b0;
            q_nxt.st     = ST_IDLE;
        end

        // Read data
        unique case (idx)
            REG_CONTROL_A:    rd_mux = {24'h0, q_r.ctla & 8'hBF};
            REG_ACCUM_CTRL:   rd_mux = {24'h0, q_r.accc};
            REG_CLKDIV_CTRL:  rd_mux = {24'h0, q_r.divc};
            REG_DELAY_CTRL:   rd_mux = {24'h0, q_r.dlyc};
            REG_WINMODE_CTRL: rd_mux = {24'h0, q_r.winc};
            REG_SAMPLE_LEN:   rd_mux = {24'h0, q_r.slen};
            REG_POS_SEL:      rd_mux = {24'h0, q_r.psel};
            REG_NEG_SEL:      rd_mux = {24'h0, q_r.nsel};
            REG_CONV_CMD:     rd_mux = {31'h0, q_r.begin_conversion_bit};
            REG_EVENT_CTRL:   rd_mux = {31'h0, q_r.evctl};
            REG_IRQ_ENABLE:   rd_mux = {30'h0, q_r.ien};
            REG_IRQ_FLAGS:    rd_mux = {30'h0, q_r.iflg};
            REG_DEBUG:        rd_mux = {31'h0, q_r.dbg};
            REG_BYTE_STAGE:   rd_mux = {24'h0, q_r.tmp};
            REG_CONV_OUT:     rd_mux = {16'h0, q_r.res};
            REG_WIN_LOW:      rd_mux = {16'h0, q_r.window_low_threshold};
            REG_WIN_HIGH:     rd_mux = {16'h0, q_r.window_high_threshold};
            default:          rd_mux = 32'h0000_0000;
        endcase
        q_nxt.rdat = rd ? rd_mux : 32'h0000_0000;
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_r       <= '0;
            q_r.ctla  <= RESET_BYTE;
            q_r.st    <= ST_IDLE;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Outputs
    assign wb_rsp_o.ack       = q_r.ack;
    assign wb_rsp_o.dat       = q_r.rdat;
    assign result_ready_evt_o = q_r.evp;
    assign irq_result_ready_o = q_r.ien[BIT_RESULT_READY] && q_r.iflg[BIT_RESULT_READY];
    assign irq_window_o       = q_r.ien[BIT_WINCMP] && q_r.iflg[BIT_WINCMP];
    assign clk_request_o      = standby_i && (q_r.st != ST_IDLE);
    assign conv_busy_o        = q_r.begin_conversion_bit;
endmodule

// ### verif/adcec_evnet_model.sv
`timescale 1ns/100ps
module adcec_evnet_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       fire_i,
    input  wire logic       result_ready_evt_i,
    output logic            start_event_o,
    output logic [7:0]      evt_count_o
);
    logic [2:0] hold_r;
    // Start event held six clocks per request, low between; completion pulses counted
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_r <= 3'h0;
            evt_count_o <= 8'h00;
        end else begin
            if (fire_i) begin
                hold_r <= 3'h6;
            end else if (hold_r != 3'h0) begin
                hold_r <= hold_r - 3'h1;
            end
            if (result_ready_evt_i) begin
                evt_count_o <= evt_count_o + 8'h01;
            end
        end
    end
    assign start_event_o = (hold_r != 3'h0);
endmodule

// ### verif/adcec_top_asserts.sv
`timescale 1ns/100ps
module adcec_top_chk import adcec_pkg::*; (
    input wire logic          clk_i,
    input wire logic          rst_i,
    input wire adcec_wb_req_t wb_req_i,
    input wire adcec_wb_rsp_t wb_rsp_o,
    input wire logic          start_event_i,
    input wire logic [11:0]   sample_i,
    input wire logic          debug_halt_i,
    input wire logic          standby_i,
    input wire logic          powerdown_i,
    input wire logic          result_ready_evt_o,
    input wire logic          irq_result_ready_o,
    input wire logic          irq_window_o,
    input wire logic          clk_request_o,
    input wire logic          conv_busy_o
);
    logic wr_now;
    // Bus write taken at this edge
    assign wr_now = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !wb_rsp_o.ack;
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_evt_pulse;
        result_ready_evt_o ##1 !result_ready_evt_o;
    endsequence
    property p_evt_pulse;
        result_ready_evt_o |-> s_evt_pulse;
    endproperty
    a_evt_pulse: assert property (p_evt_pulse) else $error("event pulse too long");
    property p_busy_fall;
        $fell(conv_busy_o) |-> result_ready_evt_o || $past(wr_now);
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("begin bit cleared early");
    property p_busy_rise;
        $rose(conv_busy_o) |-> $past(wr_now) || $past(start_event_i, 2);
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("begin bit set uncaused");
    property p_evt_busy;
        result_ready_evt_o |-> $past(conv_busy_o);
    endproperty
    a_evt_busy: assert property (p_evt_busy) else $error("completion without start");
    property p_rr_hold;
        irq_result_ready_o && !wr_now |=> irq_result_ready_o;
    endproperty
    a_rr_hold: assert property (p_rr_hold) else $error("result irq dropped");
    property p_win_hold;
        irq_window_o && !wr_now |=> irq_window_o;
    endproperty
    a_win_hold: assert property (p_win_hold) else $error("window irq dropped");
    property p_rr_rise;
        $rose(irq_result_ready_o) |-> result_ready_evt_o || $past(wr_now);
    endproperty
    a_rr_rise: assert property (p_rr_rise) else $error("result irq uncaused");
    property p_clk_req;
        clk_request_o |-> standby_i;
    endproperty
    a_clk_req: assert property (p_clk_req) else $error("clock request outside standby");
    property p_pd_freeze;
        powerdown_i && $past(powerdown_i) |-> !result_ready_evt_o;
    endproperty
    a_pd_freeze: assert property (p_pd_freeze) else $error("completion in power-down");
endmodule

bind adcec_top adcec_top_chk adcec_top_chk_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .start_event_i(start_event_i),
    .sample_i(sample_i), .debug_halt_i(debug_halt_i), .standby_i(standby_i),
    .powerdown_i(powerdown_i), .result_ready_evt_o(result_ready_evt_o),
    .irq_result_ready_o(irq_result_ready_o), .irq_window_o(irq_window_o),
    .clk_request_o(clk_request_o), .conv_busy_o(conv_busy_o));

// ### verif/tb_top.sv
`timescale 1ns/100ps
module tb_top import adcec_pkg::*;;
    typedef struct packed {
        logic [4:0]  idx;
        logic [15:0] wd;
        logic [15:0] ex;
    } adcec_row_t;
    logic          clk_i;
    logic          rst_i;
    adcec_wb_req_t req;
    adcec_wb_rsp_t rsp;
    logic          start_ev, fire, dbg_halt, stby, pdown, evt, irq_rr, irq_win, clk_req, busy;
    logic [11:0]   sample;
    logic [7:0]    ev_cnt, c0;
    logic [15:0]   rd;
    int            miscompares = 0, num_checks = 0, cyc_cnt = 0;
    adcec_row_t    rows [16] = '{
        '{REG_CONTROL_A, 16'h00F0, 16'h00B0}, '{REG_ACCUM_CTRL, 16'h0003, 16'h0003},
        '{REG_CLKDIV_CTRL, 16'h000D, 16'h000D}, '{REG_DELAY_CTRL, 16'h00FF, 16'h00EF},
        '{REG_WINMODE_CTRL, 16'h0004, 16'h0004}, '{REG_SAMPLE_LEN, 16'h00A5, 16'h00A5},
        '{REG_POS_SEL, 16'h0012, 16'h0012}, '{REG_NEG_SEL, 16'h0021, 16'h0021},
        '{REG_EVENT_CTRL, 16'h0001, 16'h0001}, '{REG_IRQ_ENABLE, 16'h0003, 16'h0003},
        '{REG_DEBUG, 16'h0001, 16'h0001}, '{REG_BYTE_STAGE, 16'h005A, 16'h005A},
        '{REG_CONV_OUT, 16'hFFFF, 16'h0000}, '{REG_WIN_LOW, 16'h1234, 16'h1234},
        '{REG_WIN_HIGH, 16'hBEEF, 16'hBEEF}, '{5'h06, 16'h00FF, 16'h0000}};

    adcec_top adcec_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
        .start_event_i(start_ev), .sample_i(sample), .debug_halt_i(dbg_halt),
        .standby_i(stby), .powerdown_i(pdown), .result_ready_evt_o(evt),
        .irq_result_ready_o(irq_rr), .irq_window_o(irq_win), .clk_request_o(clk_req),
        .conv_busy_o(busy));
    adcec_evnet_model adcec_evnet_model_i (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
        .result_ready_evt_i(evt), .start_event_o(start_ev), .evt_count_o(ev_cnt));

    // Clock and hang guard
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            miscompares++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
        num_checks++;
        if (got !== ex) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic chkb(input string nm, input logic ex, input logic got);
        chk(nm, {15'h0000, ex}, {15'h0000, got});
    endtask
    // Classic single Wishbone cycle, held until ack
    task automatic bus(input logic [4:0] idx, input logic we, input logic [15:0] wd);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {1'b0, idx, 2'b00}, sel: 4'h3,
                 dat: {16'h0000, wd}};
        @(posedge clk_i);
        while (rsp.ack !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = rsp.dat[15:0];
        req <= '{default: '0};
        @(posedge clk_i);
    endtask
    task automatic rdchk(input logic [4:0] idx, input logic [15:0] ex);
        bus(idx, 1'b0, 16'h0000);
        chk($sformatf("reg %0h", idx), ex, rd);
    endtask
    task automatic wait_evt();
        int n;
        n = 0;
        @(posedge clk_i);
        while (evt !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        chkb("evt", 1'b1, evt);
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    initial begin
        req <= '{default: '0};
        rst_i <= 1'b1;
        fire <= 1'b0;
        dbg_halt <= 1'b0;
        stby <= 1'b0;
        pdown <= 1'b0;
        sample <= 12'h800;
        pause(3);
        rst_i <= 1'b0;
        pause(1);
        // Reset values, then write and read back each row
        foreach (rows[i]) rdchk(rows[i].idx, 16'h0000);
        foreach (rows[i]) begin
            bus(rows[i].idx, 1'b1, rows[i].wd);
            rdchk(rows[i].idx, rows[i].ex);
        end
        rst_i <= 1'b1;
        pause(1);
        rst_i <= 1'b0;
        pause(1);
        rdchk(REG_DEBUG, 16'h0000);
        $display("test registers done");
        // Software start, outside-window result, flags and clearing
        bus(REG_WIN_LOW, 1'b1, 16'h0100);
        bus(REG_WIN_HIGH, 1'b1, 16'h0200);
        bus(REG_WINMODE_CTRL, 1'b1, {13'h0000, WIN_OUTSIDE});
        bus(REG_IRQ_ENABLE, 1'b1, 16'h0003);
        bus(REG_CONTROL_A, 1'b1, 16'h0001);
        bus(REG_CONV_CMD, 1'b1, 16'h0001);
        chkb("busy", 1'b1, busy);
        wait_evt();
        chkb("busy", 1'b0, busy);
        rdchk(REG_CONV_OUT, 16'h0800);
        rdchk(REG_IRQ_FLAGS, 16'h0003);
        chkb("irq_rr", 1'b1, irq_rr);
        chkb("irq_win", 1'b1, irq_win);
        bus(REG_IRQ_FLAGS, 1'b1, 16'h0001);
        rdchk(REG_IRQ_FLAGS, 16'h0002);
        bus(REG_IRQ_FLAGS, 1'b1, 16'h0000);
        rdchk(REG_IRQ_FLAGS, 16'h0002);
        chkb("irq_rr", 1'b0, irq_rr);
        bus(REG_IRQ_FLAGS, 1'b1, 16'h0002);
        chkb("irq_win", 1'b0, irq_win);
        $display("test software start done");
        // Event start with interrupts masked
        bus(REG_IRQ_ENABLE, 1'b1, 16'h0000);
        bus(REG_EVENT_CTRL, 1'b1, 16'h0001);
        sample <= 12'h0FF;
        fire <= 1'b1;
        pause(1);
        fire <= 1'b0;
        wait_evt();
        rdchk(REG_CONV_OUT, 16'h00FF);
        rdchk(REG_IRQ_FLAGS, 16'h0003);
        chkb("irq_rr", 1'b0, irq_rr);
        bus(REG_IRQ_FLAGS, 1'b1, 16'h0003);
        $display("test event start done");
        // Free-running, then halted by command
        bus(REG_CONTROL_A, 1'b1, 16'h0003);
        bus(REG_CONV_CMD, 1'b1, 16'h0001);
        wait_evt();
        wait_evt();
        chkb("busy", 1'b1, busy);
        bus(REG_CONV_CMD, 1'b1, 16'h0002);
        pause(60);
        chkb("busy", 1'b0, busy);
        $display("test free running done");
        // Power-down freezes a running conversion
        bus(REG_CONTROL_A, 1'b1, 16'h0001);
        bus(REG_CONV_CMD, 1'b1, 16'h0001);
        c0 = ev_cnt;
        pause(10);
        pdown <= 1'b1;
        pause(100);
        chkb("busy", 1'b1, busy);
        chk("evt count", {8'h00, c0}, {8'h00, ev_cnt});
        pdown <= 1'b0;
        wait_evt();
        rdchk(REG_CONV_OUT, 16'h0000);
        $display("test power-down done");
        // Debug halt freezes unless kept running
        bus(REG_CONV_CMD, 1'b1, 16'h0001);
        c0 = ev_cnt;
        pause(10);
        dbg_halt <= 1'b1;
        pause(100);
        chk("evt count", {8'h00, c0}, {8'h00, ev_cnt});
        dbg_halt <= 1'b0;
        wait_evt();
        bus(REG_DEBUG, 1'b1, 16'h0001);
        bus(REG_CONV_CMD, 1'b1, 16'h0001);
        dbg_halt <= 1'b1;
        wait_evt();
        dbg_halt <= 1'b0;
        $display("test debug done");
        // Standby with run-in-standby: event starts only, clock on demand
        bus(REG_DELAY_CTRL, 1'b1, 16'h0020);
        bus(REG_CONTROL_A, 1'b1, 16'h0081);
        stby <= 1'b1;
        bus(REG_CONV_CMD, 1'b1, 16'h0001);
        chkb("busy", 1'b0, busy);
        chkb("clk_req", 1'b0, clk_req);
        fire <= 1'b1;
        pause(1);
        fire <= 1'b0;
        pause(12);
        chkb("clk_req", 1'b1, clk_req);
        wait_evt();
        pause(2);
        chkb("clk_req", 1'b0, clk_req);
        stby <= 1'b0;
        $display("test standby done");
        // Two-sample accumulation, window inside, one completion; idle power-down
        bus(REG_ACCUM_CTRL, 1'b1, 16'h0001);
        bus(REG_WINMODE_CTRL, 1'b1, {13'h0000, WIN_INSIDE});
        bus(REG_IRQ_FLAGS, 1'b1, 16'h0003);
        c0 = ev_cnt;
        bus(REG_CONV_CMD, 1'b1, 16'h0001);
        wait_evt();
        rdchk(REG_CONV_OUT, 16'h01FE);
        rdchk(REG_IRQ_FLAGS, 16'h0003);
        chk("evt count", {8'h00, c0 + 8'h01}, {8'h00, ev_cnt});
        pdown <= 1'b1;
        pause(4);
        pdown <= 1'b0;
        rdchk(REG_CONV_OUT, 16'h01FE);
        $display("test accumulation done");
        final_report();
    end
endmodule
